// *** core/dac_port_consts.svh ***
// timing and field constants for the dual dac parallel port host
`ifndef DAC_PORT_CONSTS_SVH
`define DAC_PORT_CONSTS_SVH
`define CLK_PERIOD_NS      10
`define CODE_MSB           11
`define CODE_WIDTH         12
`define ZERO_CODE          12'h000
// setup of address and r/w ahead of chip select low, ns
`define T_ADDR_SETUP_NS    10
// chip select low time, ns
`define T_CS_LOW_NS        10
// data access time on readback, ns (max)
`define T_ACCESS_NS        35
// chip select high time before next access, ns
`define T_CS_HIGH_NS       7
// bus relinquish time after read, ns (max)
`define T_RELINQ_NS        10
// load strobe pulse width, ns
`define T_LOAD_PULSE_NS    12
// chip select rising to load strobe falling, ns
`define T_CS_TO_LOAD_NS    10
// cycles, rounded up, never below one
`define CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CNT_W              4
`endif

// *** core/dac_port_pkg.sv ***
// types for the dual dac parallel port host
`include "dac_port_consts.svh"
package dac_port_pkg;
	typedef logic [`CODE_MSB:0] code_t;

	// one host command
	typedef struct packed {
		logic  read;    // 1 readback, 0 write
		logic  chan_b;  // 0 channel a, 1 channel b
		logic  load;    // pulse the load strobe after a write
		code_t code;    // write data
	} cmd_t;

	// pins driven toward the device
	typedef struct packed {
		logic  cs_n;
		logic  rd_wr_n;
		logic  chan_sel;
		logic  load_n;
		logic  clear_n;
		logic  data_oe;
		code_t data_out;
	} pins_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_SETUP   = 3'b001,
		ST_LOW     = 3'b010,
		ST_HIGH    = 3'b011,
		ST_GAP     = 3'b100,
		ST_LOAD    = 3'b101,
		ST_CLEAR   = 3'b110
	} state_t;
endpackage

// *** core/dac_port_host.sv ***
// host controller driving the dual dac parallel load port
`timescale 1ns/1ns
`include "dac_port_consts.svh"
module dac_port_host #(
	parameter int AUTO_UPDATE = 0   // 1 holds load strobe low permanently
) (
	input  wire logic                  clk,          // 100 MHz clock
	input  wire logic                  reset,        // async reset, active high
	input  wire logic                  cmd_valid,    // command offered
	output logic                       cmd_ready,    // command taken this cycle
	input  wire dac_port_pkg::cmd_t    cmd,          // command contents
	input  wire logic                  clear_req,    // request a clear pulse
	output logic                       rd_valid,     // readback data valid pulse
	output dac_port_pkg::code_t        rd_data,      // readback code
	output logic                       cs_n,         // chip select, active low
	output logic                       rd_wr_n,      // high read, low write
	output logic                       chan_sel,     // low channel a, high b
	output logic                       output_load_strobe_n, // load strobe
	output logic                       clear_all_n,  // clear, active low
	output dac_port_pkg::code_t        parallel_data_bus_o,  // bus out
	output logic                       parallel_data_bus_oe, // bus enable
	input  wire dac_port_pkg::code_t   parallel_data_bus_i   // bus in
);
	localparam logic [`CNT_W-1:0] SETUP_C = `CNT_W'(`CYC(`T_ADDR_SETUP_NS));
	localparam logic [`CNT_W-1:0] WLOW_C  = `CNT_W'(`CYC(`T_CS_LOW_NS));
	localparam logic [`CNT_W-1:0] RLOW_C  = `CNT_W'(`CYC(`T_ACCESS_NS));
	localparam logic [`CNT_W-1:0] HIGH_C  = `CNT_W'(`CYC(`T_CS_HIGH_NS));
	localparam logic [`CNT_W-1:0] RELQ_C  = `CNT_W'(`CYC(`T_RELINQ_NS));
	localparam logic [`CNT_W-1:0] LDLY_C  = `CNT_W'(`CYC(`T_CS_TO_LOAD_NS));
	localparam logic [`CNT_W-1:0] LPUL_C  = `CNT_W'(`CYC(`T_LOAD_PULSE_NS));

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// the strobe has two idle levels only, so refuse anything else
	if (AUTO_UPDATE != 0 && AUTO_UPDATE != 1) begin
		$error("AUTO_UPDATE must be 0 or 1");
	end
	// a phase count that overflows the shared down counter would cut that phase short
	if (`CYC(`T_ACCESS_NS) >= (1 << `CNT_W)) begin
		$error("access window does not fit the phase counter");
	end
	if (`CYC(`T_LOAD_PULSE_NS) >= (1 << `CNT_W)) begin
		$error("load pulse does not fit the phase counter");
	end
	if (`CYC(`T_CS_TO_LOAD_NS) >= (1 << `CNT_W)) begin
		$error("load delay does not fit the phase counter");
	end
	if (`CYC(`T_ADDR_SETUP_NS) >= (1 << `CNT_W)) begin
		$error("address setup does not fit the phase counter");
	end
	if (`CYC(`T_CS_LOW_NS) >= (1 << `CNT_W)) begin
		$error("select low time does not fit the phase counter");
	end
	if (`CYC(`T_CS_HIGH_NS) >= (1 << `CNT_W)) begin
		$error("select high time does not fit the phase counter");
	end
	if (`CYC(`T_RELINQ_NS) >= (1 << `CNT_W)) begin
		$error("bus release time does not fit the phase counter");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	dac_port_pkg::state_t state_q, state_d;
	dac_port_pkg::cmd_t   cmd_q, cmd_d;
	dac_port_pkg::pins_t  pins_q, pins_d;
	logic [`CNT_W-1:0]    cnt_q, cnt_d;
	logic                 load_pend_q, load_pend_d;
	logic                 rd_valid_q, rd_valid_d;
	dac_port_pkg::code_t  rd_data_q, rd_data_d;

	wire logic cnt_done = (cnt_q == `CNT_W'(1));
	wire logic load_idle = (AUTO_UPDATE == 1) ? 1'b0 : 1'b1;
	// phase lengths follow the latched direction; a read holds select for the access time
	wire logic [`CNT_W-1:0] low_len  = cmd_q.read ? RLOW_C : WLOW_C;
	wire logic [`CNT_W-1:0] high_len = cmd_q.read ? RELQ_C : HIGH_C;
	// the down counter parks at zero in idle between accesses
	wire logic [`CNT_W-1:0] cnt_dec  = (cnt_q > `CNT_W'(0)) ? cnt_q - `CNT_W'(1) : cnt_q;
	// only strobed writes need the separate load pulse
	wire logic              want_load = !cmd.read && cmd.load && (AUTO_UPDATE == 0);
	assign cmd_ready = (state_q == dac_port_pkg::ST_IDLE) && !clear_req;

	// one access walks setup, select low, select high, then for a strobed write a gap
	// and the load pulse; each phase length is loaded into the down counter on entry
	// and the phase ends when the counter reaches one
	// next-state logic; clear requests beat new commands so a stuck host can recover
	always_comb begin
		state_d     = state_q;
		cmd_d       = cmd_q;
		pins_d      = pins_q;
		cnt_d       = cnt_dec;
		load_pend_d = load_pend_q;
		rd_valid_d  = 1'b0;
		rd_data_d   = rd_data_q;
		case (state_q)
			dac_port_pkg::ST_IDLE: begin
				if (clear_req) begin
					pins_d.clear_n = 1'b0;
					cnt_d          = LPUL_C;
					state_d        = dac_port_pkg::ST_CLEAR;
				end else if (cmd_valid) begin
					cmd_d            = cmd;
					pins_d.rd_wr_n   = cmd.read;
					pins_d.chan_sel  = cmd.chan_b;
					pins_d.data_out  = cmd.code;
					pins_d.data_oe   = !cmd.read;
					load_pend_d      = want_load;
					cnt_d            = SETUP_C;
					state_d          = dac_port_pkg::ST_SETUP;
				end
			end
			dac_port_pkg::ST_SETUP: begin
				if (cnt_done) begin
					pins_d.cs_n = 1'b0;
					cnt_d       = low_len;
					state_d     = dac_port_pkg::ST_LOW;
				end
			end
			dac_port_pkg::ST_LOW: begin
				if (cnt_done) begin
					// cs rise latches write data in the device
					pins_d.cs_n = 1'b1;
					if (cmd_q.read) begin
						rd_data_d  = parallel_data_bus_i;
						rd_valid_d = 1'b1;
					end
					cnt_d   = high_len;
					state_d = dac_port_pkg::ST_HIGH;
				end
			end
			dac_port_pkg::ST_HIGH: begin
				if (cnt_done) begin
					pins_d.data_oe = 1'b0;
					if (load_pend_q) begin
						cnt_d   = LDLY_C;
						state_d = dac_port_pkg::ST_GAP;
					end else begin
						state_d = dac_port_pkg::ST_IDLE;
					end
				end
			end
			dac_port_pkg::ST_GAP: begin
				if (cnt_done) begin
					// strobe falling moves the latch to the output
					pins_d.load_n = 1'b0;
					cnt_d         = LPUL_C;
					state_d       = dac_port_pkg::ST_LOAD;
				end
			end
			dac_port_pkg::ST_LOAD: begin
				if (cnt_done) begin
					pins_d.load_n = load_idle;
					load_pend_d   = 1'b0;
					state_d       = dac_port_pkg::ST_IDLE;
				end
			end
			dac_port_pkg::ST_CLEAR: begin
				if (cnt_done) begin
					pins_d.clear_n = 1'b1;
					state_d        = dac_port_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = dac_port_pkg::ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// reset leaves the bus released and the strobe idle; codes are plain unsigned
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q     <= dac_port_pkg::ST_IDLE;
			cmd_q       <= '0;
			pins_q      <= '{cs_n: 1'b1, rd_wr_n: 1'b1, chan_sel: 1'b0,
				load_n: (AUTO_UPDATE == 1) ? 1'b0 : 1'b1, clear_n: 1'b1,
				data_oe: 1'b0, data_out: `ZERO_CODE};
			cnt_q       <= '0;
			load_pend_q <= 1'b0;
			rd_valid_q  <= 1'b0;
			rd_data_q   <= `ZERO_CODE;
		end else begin
			state_q     <= state_d;
			cmd_q       <= cmd_d;
			pins_q      <= pins_d;
			cnt_q       <= cnt_d;
			load_pend_q <= load_pend_d;
			rd_valid_q  <= rd_valid_d;
			rd_data_q   <= rd_data_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cs_n                 = pins_q.cs_n;
	assign rd_wr_n              = pins_q.rd_wr_n;
	assign chan_sel             = pins_q.chan_sel;
	assign output_load_strobe_n = pins_q.load_n;
	assign clear_all_n          = pins_q.clear_n;
	assign parallel_data_bus_o  = pins_q.data_out;
	assign parallel_data_bus_oe = pins_q.data_oe;
	assign rd_valid             = rd_valid_q;
	assign rd_data              = rd_data_q;
endmodule

// *** testbench/dac_port_host_properties.sv ***
// pin timing checker for the dac port host
`timescale 1ns/1ns
module dac_port_host_properties (
	input wire logic                clk,                  // clock
	input wire logic                reset,                // reset
	input wire logic                cs_n,                 // select
	input wire logic                rd_wr_n,              // direction
	input wire logic                chan_sel,             // channel
	input wire dac_port_pkg::code_t parallel_data_bus_o,  // bus out
	input wire logic                parallel_data_bus_oe, // bus enable
	input wire logic                output_load_strobe_n, // load strobe
	input wire logic                clear_all_n           // clear, active low
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// channel and direction may not move under a live select
	property p_sel_hold;
		!cs_n |=> $stable(chan_sel) && $stable(rd_wr_n);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("channel moved");
	// the device latches on the rise, so data must hold to it
	property p_data;
		!cs_n && !rd_wr_n |=> $stable(parallel_data_bus_o);
	endproperty
	a_data: assert property (p_data) else $error("write data moved");
	// readback: four low cycles with the bus left to the device
	property p_rd_len;
		$fell(cs_n) && rd_wr_n |-> (!cs_n && !parallel_data_bus_oe)[*4] ##1 cs_n;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("bad read frame");
	// write: host drives the bus, select low one cycle
	property p_wr_len;
		$fell(cs_n) && !rd_wr_n |-> parallel_data_bus_oe ##1 cs_n;
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("bad write frame");
	// strobe pulse is two cycles and falls only once select is back high
	property p_load_len;
		$fell(output_load_strobe_n) |->
			(!output_load_strobe_n && cs_n)[*2] ##1 output_load_strobe_n;
	endproperty
	a_load_len: assert property (p_load_len) else $error("bad load pulse");
	// clear pulse is two cycles and never overlaps an access
	property p_clear_len;
		$fell(clear_all_n) |-> (!clear_all_n && cs_n)[*2] ##1 clear_all_n;
	endproperty
	a_clear_len: assert property (p_clear_len) else $error("bad clear pulse");
	// the host never fights the device on a readback
	property p_rd_release;
		!cs_n && rd_wr_n |-> !parallel_data_bus_oe;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("bus driven in read");
endmodule
bind dac_port_host dac_port_host_properties u_props (.clk, .reset, .cs_n, .rd_wr_n,
	.chan_sel, .parallel_data_bus_o, .parallel_data_bus_oe, .output_load_strobe_n,
	.clear_all_n);

// *** testbench/dac_dev_model.sv ***
// behavioural model of the dual dac device
`timescale 1ns/1ns
module dac_dev_model (
	input  wire logic                cs_n,     // select
	input  wire logic                rd_wr_n,  // direction
	input  wire logic                chan_sel, // channel
	input  wire logic                load_n,   // load strobe
	input  wire logic                clear_n,  // clear
	input  wire dac_port_pkg::code_t bus,      // resolved bus
	output dac_port_pkg::code_t      drv       // device drive
);
	dac_port_pkg::code_t lat [2] = '{2{12'h000}};
	dac_port_pkg::code_t dac [2] = '{2{12'h000}};
	// released bus shows the inverse, so a stray sample cannot match
	assign drv = (!cs_n && rd_wr_n) ? dac[chan_sel] : ~dac[chan_sel];
	// latch on the select rise
	always @(posedge cs_n) begin
		if (clear_n && !rd_wr_n) begin
			lat[chan_sel] = bus;
			if (!load_n) dac = lat;
		end
	end
	// a high strobe keeps the output
	always @(negedge load_n) begin
		if (clear_n) dac = lat;
	end
	always @(negedge clear_n) begin
		lat = '{2{12'h000}};
		dac = '{2{12'h000}};
	end
endmodule

// *** testbench/dac_port_host_tb.sv ***
// self-checking bench for the dac port host
`timescale 1ns/1ns
module dac_port_host_tb;
	logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, clear_req = 1'b0;
	logic cmd_ready, rd_valid, cs_n, rd_wr_n, chan_sel, load_n, clear_n, h_oe;
	dac_port_pkg::cmd_t  cmd = '0;
	dac_port_pkg::code_t rd_data, h_bus, d_bus, bus;
	int n_mismatch = 0, n_checks = 0;
	// second host, strobe tied low; on_auto steers the tasks to it
	logic au_valid = 1'b0, on_auto = 1'b0;
	logic au_ready, au_rd_valid, au_cs_n, au_rd_wr_n, au_sel, au_load_n, au_clear_n, au_oe;
	dac_port_pkg::code_t au_rd_data, au_h_bus, au_d_bus, au_bus;
	assign bus = h_oe ? h_bus : d_bus;
	assign au_bus = au_oe ? au_h_bus : au_d_bus;
	always #5 clk = ~clk;
	dac_port_host #(.AUTO_UPDATE(0)) u_dut (.clk, .reset, .cmd_valid, .cmd_ready, .cmd,
		.clear_req, .rd_valid, .rd_data, .cs_n, .rd_wr_n, .chan_sel,
		.output_load_strobe_n(load_n), .clear_all_n(clear_n), .parallel_data_bus_o(h_bus),
		.parallel_data_bus_oe(h_oe), .parallel_data_bus_i(bus));
	dac_dev_model u_dev (.cs_n, .rd_wr_n, .chan_sel, .load_n, .clear_n, .bus, .drv(d_bus));
	// the automatic update mode is otherwise never reached
	dac_port_host #(.AUTO_UPDATE(1)) u_dut_auto (.clk, .reset, .cmd_valid(au_valid),
		.cmd_ready(au_ready), .cmd, .clear_req, .rd_valid(au_rd_valid),
		.rd_data(au_rd_data), .cs_n(au_cs_n), .rd_wr_n(au_rd_wr_n), .chan_sel(au_sel),
		.output_load_strobe_n(au_load_n), .clear_all_n(au_clear_n),
		.parallel_data_bus_o(au_h_bus), .parallel_data_bus_oe(au_oe),
		.parallel_data_bus_i(au_bus));
	dac_dev_model u_dev_auto (.cs_n(au_cs_n), .rd_wr_n(au_rd_wr_n), .chan_sel(au_sel),
		.load_n(au_load_n), .clear_n(au_clear_n), .bus(au_bus), .drv(au_d_bus));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic send(input logic rd, b, ld, input dac_port_pkg::code_t c);
		@(negedge clk);
		cmd = '{rd, b, ld, c};
		if (on_auto) au_valid = 1'b1;
		else cmd_valid = 1'b1;
		while (!(on_auto ? au_ready : cmd_ready)) @(negedge clk);
		@(negedge clk);
		if (on_auto) au_valid = 1'b0;
		else cmd_valid = 1'b0;
	endtask
	// a missing pulse is a mismatch by itself, whatever the data shows
	task automatic rd_chk(input logic b, input dac_port_pkg::code_t exp);
		int i;
		logic got_valid;
		dac_port_pkg::code_t got;
		send(1'b1, b, 1'b0, 12'h000);
		for (i = 0; i < 20 && (on_auto ? au_rd_valid : rd_valid) !== 1'b1; i++) @(negedge clk);
		got_valid = on_auto ? au_rd_valid : rd_valid;
		got       = on_auto ? au_rd_data : rd_data;
		n_checks++;
		if (got_valid !== 1'b1 || got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic t_powerup;
		rd_chk(1'b0, 12'h000);
		rd_chk(1'b1, 12'h000);
	endtask
	task automatic t_hold_load;
		send(1'b0, 1'b0, 1'b0, 12'hFFF);
		rd_chk(1'b0, 12'h000);
		send(1'b0, 1'b1, 1'b1, 12'h800);
		rd_chk(1'b1, 12'h800);
		rd_chk(1'b0, 12'hFFF);
	endtask
	task automatic t_clear;
		@(negedge clk);
		clear_req = 1'b1;
		@(negedge clk);
		clear_req = 1'b0;
		rd_chk(1'b1, 12'h000);
		send(1'b0, 1'b0, 1'b1, 12'h001);
		rd_chk(1'b0, 12'h001);
	endtask
	// reset in the gap before the load pulse aborts the pulse and idles the pins
	task automatic t_reset;
		send(1'b0, 1'b0, 1'b1, 12'h7FF);
		repeat (3) @(negedge clk);
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		n_checks++;
		if ({cs_n, load_n, clear_n, h_oe} !== 4'hE) begin
			n_mismatch++;
			$display("MISMATCH t=%0t pins not idle after reset", $time);
		end
		n_checks++;
		if (au_load_n !== 1'b0) begin
			n_mismatch++;
			$display("MISMATCH t=%0t tied strobe not low after reset", $time);
		end
		rd_chk(1'b0, 12'h001);
		send(1'b0, 1'b1, 1'b1, 12'h0F0);
		rd_chk(1'b0, 12'h7FF);
	endtask
	// with the strobe held low the select rise alone updates the output
	task automatic t_auto;
		on_auto = 1'b1;
		send(1'b0, 1'b1, 1'b0, 12'hABC);
		rd_chk(1'b1, 12'hABC);
		rd_chk(1'b0, 12'h000);
		on_auto = 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_powerup;
		t_hold_load;
		t_clear;
		t_reset;
		t_auto;
		report_and_stop;
	end
	// about 130 cycles of traffic, so 2000 means a hang
	initial begin
		#20000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
